// ### rtl/ldl_latch_bank.v
// serial latch bank with pwm, brightness, correction and parameter latches
`timescale 1ns/1ps
`default_nettype none
`include "ldl_regs.vh"

// three-flop synchroniser for one pin
module ldl_sync3 (
  input  wire       clk,
  input  wire       rst,
  input  wire       pin,
  output wire [2:0] stages
);
  reg [2:0] syncReg;
  assign stages = syncReg;
  // pin enters stage one; only stage two reads it, stages two and three feed the filter
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      syncReg <= 3'h0;
    end else begin
      syncReg <= {syncReg[1:0], pin};
    end
  end
endmodule

// one channel compare of the counter against its level
module ldl_pwm_cmp (
  input  wire [11:0] count,
  input  wire [11:0] level,
  output wire        hit
);
  // channel on while the counter is below its level
  assign hit = (count < level);
endmodule

module ldl_latch_bank #(
  parameter [20:0] NV_CORR_DEFAULT = 21'h1fffff
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        clkIn,
  input  wire        datIn,
  input  wire        latchPulse,
  input  wire        intTick,
  output reg         clkOut,
  output reg         datOut,
  output reg  [2:0]  ledSinkOutput,
  output reg  [6:0]  globalBrightness,
  output reg  [20:0] currentCorrection,
  output reg  [2:0]  switchOnDutyCode,
  output reg  [4:0]  anodeTargetCode,
  output reg  [1:0]  linkTimingMode,
  output reg  [3:0]  latchDelayCode,
  output reg  [6:0]  onDutyPercent,
  output reg  [15:0] anodeTargetMv,
  output reg         nvProgramReq
);
  localparam [11:0] GS_LAST = 12'hfff;
  localparam [4:0]  DOUT_CYC = `LDL_DOUT_CYC;

  // three-stage synchronisers for link clock and data
  wire [2:0] clkSync;
  wire [2:0] datSync;
  ldl_sync3 clk_sync_u (
    .clk    (clk),
    .rst    (rst),
    .pin    (clkIn),
    .stages (clkSync)
  );
  ldl_sync3 dat_sync_u (
    .clk    (clk),
    .rst    (rst),
    .pin    (datIn),
    .stages (datSync)
  );

  // filtered clock level changes once stages two and three agree
  reg clkLevel;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      clkLevel <= 1'b0;
    end else if (clkSync[1] == clkSync[2]) begin
      clkLevel <= clkSync[2];
    end
  end
  wire next_rise;
  wire next_fall;
  assign next_rise = (clkSync[1] == clkSync[2]) && clkSync[2] && !clkLevel;
  assign next_fall = (clkSync[1] == clkSync[2]) && !clkSync[2] && clkLevel;

  // 40-bit common shift register
  reg [39:0] shiftReg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      shiftReg <= 40'h0;
    end else if (next_rise) begin
      shiftReg <= {shiftReg[38:0], datSync[2]};
    end
  end
  wire [3:0]  addr;
  wire [35:0] data;
  assign addr = shiftReg[39:36];
  assign data = shiftReg[35:0];

  // latch pulse from the same clock domain, edge found locally
  reg latchPrev;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      latchPrev <= 1'b0;
    end else begin
      latchPrev <= latchPulse;
    end
  end
  wire latchEvt;
  assign latchEvt = latchPulse && !latchPrev;
  wire wrGs;
  wire wrFc;
  wire wrDc;
  wire wrNv;
  assign wrGs = latchEvt && (addr == `LDL_ADDR_GS);
  assign wrFc = latchEvt && (addr == `LDL_ADDR_FC);
  assign wrDc = latchEvt && (addr == `LDL_ADDR_DC);
  assign wrNv = latchEvt && (addr == `LDL_ADDR_NV1);

  // function control latch; upper bits dropped
  reg [14:0] fcLatch;
  wire [14:0] fcWord;
  assign fcWord = data[`LDL_FC_W-1:0];
  wire autoRefresh;
  wire displayRepeat;
  wire extPwmClockSel;
  wire timingResetEn;
  wire correctionWriteEn;
  assign autoRefresh       = fcLatch[`LDL_REFRESH_BIT];
  assign displayRepeat     = fcLatch[`LDL_REPEAT_BIT];
  assign extPwmClockSel    = fcLatch[`LDL_EXT_PWM_CLOCK_SEL_BIT];
  assign timingResetEn     = fcLatch[`LDL_TIMING_RESET_EN_BIT];
  assign correctionWriteEn = fcLatch[`LDL_CORRECTION_WRITE_EN_BIT];
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fcLatch <= `LDL_FC_RESET;
    end else if (wrFc) begin
      fcLatch <= fcWord;
      fcLatch[`LDL_TIMING_RESET_EN_BIT] <= data[`LDL_TIMING_RESET_EN_BIT] & data[`LDL_EXT_PWM_CLOCK_SEL_BIT];
    end
  end

  // pwm clock source select
  wire gsTick;
  assign gsTick = extPwmClockSel ? next_rise : intTick;

  // grayscale counter
  reg [11:0] gsCount;
  reg        gsRun;
  reg        gsStart;
  wire       gsWrap;
  assign gsWrap = gsTick && gsRun && (gsCount == GS_LAST);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      gsCount <= 12'h0;
      gsRun   <= 1'b1;
    end else if (wrGs && timingResetEn) begin
      gsCount <= 12'h0;
      gsRun   <= 1'b1;
    end else if (gsTick && gsRun) begin
      gsCount <= gsCount + 12'h1;
      if (gsCount == GS_LAST) begin
        gsRun <= displayRepeat;
      end
    end
  end

  // first and second grayscale and brightness latches
  reg [35:0] gsFirst;
  reg [35:0] gsSecond;
  reg [6:0]  bcFirst;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      gsFirst          <= 36'h0;
      gsSecond         <= 36'h0;
      bcFirst          <= `LDL_BC_RESET;
      globalBrightness <= `LDL_BC_RESET;
    end else begin
      if (wrGs) begin
        gsFirst <= data;
        if (!autoRefresh) begin
          gsSecond <= data;
        end
      end
      if (wrFc) begin
        bcFirst <= data[6:0];
        if (!data[`LDL_REFRESH_BIT]) begin
          globalBrightness <= data[6:0];
        end
      end
      if (autoRefresh && (gsWrap || (wrGs && timingResetEn))) begin
        gsSecond         <= wrGs ? data : gsFirst;
        globalBrightness <= bcFirst;
      end
    end
  end

  // pwm compare per channel
  wire [2:0] pwmHit;
  ldl_pwm_cmp cmp0_u (
    .count (gsCount),
    .level (gsSecond[`LDL_GS0_LSB +: 12]),
    .hit   (pwmHit[0])
  );
  ldl_pwm_cmp cmp1_u (
    .count (gsCount),
    .level (gsSecond[`LDL_GS1_LSB +: 12]),
    .hit   (pwmHit[1])
  );
  ldl_pwm_cmp cmp2_u (
    .count (gsCount),
    .level (gsSecond[`LDL_GS2_LSB +: 12]),
    .hit   (pwmHit[2])
  );
  // outputs registered; a timing reset forces them off
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ledSinkOutput <= 3'h0;
    end else begin
      ledSinkOutput <= pwmHit & {3{gsRun && !(wrGs && timingResetEn)}};
    end
  end

  // correction field of the written word; upper bits ignored
  wire [20:0] dcWord;
  assign dcWord = data[`LDL_DC0_LSB +: `LDL_DC_W];

  // correction latch, loaded from nonvolatile defaults
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      currentCorrection <= 21'h0;
    end else if (wrDc && correctionWriteEn) begin
      currentCorrection <= dcWord;
    end else if (!correctionWriteEn) begin
      currentCorrection <= NV_CORR_DEFAULT;
    end
  end

  // parameter fields of the written word; bits 27-14 are not kept
  wire [2:0] nvDuty;
  wire [4:0] nvTarget;
  wire [1:0] nvMode;
  wire [3:0] nvDelay;
  wire [7:0] nvCmd;
  assign nvDuty   = data[`LDL_DUTY_LSB +: 3];
  assign nvTarget = data[`LDL_VFB_LSB +: 5];
  assign nvMode   = data[`LDL_MODE_LSB +: 2];
  assign nvDelay  = data[`LDL_DELAY_LSB +: 4];
  assign nvCmd    = data[`LDL_CMD_LSB +: 8];

  // nonvolatile parameter write latch
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      switchOnDutyCode <= `LDL_DUTY_RESET;
      anodeTargetCode  <= `LDL_VFB_RESET;
      linkTimingMode   <= `LDL_MODE_RESET;
      latchDelayCode   <= `LDL_DELAY_RESET;
      nvProgramReq     <= 1'b0;
    end else begin
      nvProgramReq <= 1'b0;
      if (wrNv) begin
        switchOnDutyCode <= nvDuty;
        anodeTargetCode  <= nvTarget;
        linkTimingMode   <= nvMode;
        latchDelayCode   <= nvDelay;
        nvProgramReq     <= (nvCmd == `LDL_NV_CMD);
      end
    end
  end

  // target millivolts; product kept at 32 bits so the top code cannot wrap
  wire [31:0] mvWide;
  assign mvWide = 32'h1b58 + ({27'h0, anodeTargetCode} * 32'h2710) / 32'h1f;

  // decode of duty and target voltage codes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      onDutyPercent <= 7'h12;
      anodeTargetMv <= 16'h1b58;
    end else begin
      case (switchOnDutyCode)
        3'h0: onDutyPercent <= 7'h12;
        3'h1: onDutyPercent <= 7'h1e;
        3'h2: onDutyPercent <= 7'h2a;
        3'h3: onDutyPercent <= 7'h37;
        3'h4: onDutyPercent <= 7'h43;
        3'h5: onDutyPercent <= 7'h50;
        default: onDutyPercent <= 7'h56;
      endcase
      anodeTargetMv <= mvWide[15:0];
    end
  end

  // forwarded clock, and data delayed from the link clock edge the selected mode picks
  reg [4:0] dCnt;
  reg       dPend;
  wire      modeZero;
  assign modeZero = (linkTimingMode == 2'h0);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      clkOut <= 1'b0;
      datOut <= 1'b0;
      dCnt   <= 5'h0;
      dPend  <= 1'b0;
    end else begin
      clkOut <= clkLevel;
      if ((modeZero && next_fall) || (!modeZero && next_rise)) begin
        dPend <= 1'b1;
        dCnt  <= DOUT_CYC;
      end else if (dPend) begin
        if (dCnt <= 5'h1) begin
          datOut <= shiftReg[39];
          dPend  <= 1'b0;
        end else begin
          dCnt <= dCnt - 5'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/ldl_regs.vh
// constants for the led driver latch bank
`ifndef LDL_REGS_VH
`define LDL_REGS_VH
`define LDL_SR_W         40
`define LDL_DATA_W       36
`define LDL_ADDR_GS      4'h0
`define LDL_ADDR_NV1     4'hc
`define LDL_ADDR_DC      4'he
`define LDL_ADDR_FC      4'hf
`define LDL_GS0_LSB      0
`define LDL_GS1_LSB      12
`define LDL_GS2_LSB      24
`define LDL_BC_LSB       0
`define LDL_REFRESH_BIT  7
`define LDL_REPEAT_BIT   8
`define LDL_EXT_PWM_CLOCK_SEL_BIT   9
`define LDL_TIMING_RESET_EN_BIT   10
`define LDL_CORRECTION_WRITE_EN_BIT    11
`define LDL_FC_W         15
`define LDL_BC_RESET     7'h7f
`define LDL_FC_RESET     15'h007f
`define LDL_DC0_LSB      0
`define LDL_DC1_LSB      7
`define LDL_DC2_LSB      14
`define LDL_DC_W         21
`define LDL_DUTY_LSB     0
`define LDL_VFB_LSB      3
`define LDL_MODE_LSB     8
`define LDL_DELAY_LSB    10
`define LDL_CMD_LSB      28
`define LDL_NV_CMD       8'ha5
`define LDL_DUTY_RESET   3'h0
`define LDL_VFB_RESET    5'h00
`define LDL_MODE_RESET   2'h0
`define LDL_DELAY_RESET  4'hf
`define LDL_GS_PERIOD    4096
`define LDL_CLK_NS       20
`define LDL_DOUT_NS      30
`define LDL_DOUT_CYC     ((`LDL_DOUT_NS + `LDL_CLK_NS - 1) / `LDL_CLK_NS)
`endif

// ### dv/ldl_host.sv
// host model shifting frames onto the serial link
`timescale 1ns/1ps
`default_nettype none
module ldl_host (
  input  wire logic clk,
  output var logic  clkIn,
  output var logic  datIn,
  output var logic  latchPulse
);
  // link clock parked low between frames
  initial begin
    clkIn = 1'b0;
    datIn = 1'b0;
    latchPulse = 1'b0;
  end
  // msb first, 160 ns per bit, low phase stretched by slow
  task automatic send(input logic [39:0] w, input int slow);
    for (int i = 39; i >= 0; i--) begin
      repeat (2) @(negedge clk);
      datIn = w[i];
      repeat (2 + slow) @(negedge clk);
      clkIn = 1'b1;
      repeat (4) @(negedge clk);
      clkIn = 1'b0;
    end
    datIn = ~datIn; // last bit inverted, no stale bit
    repeat (8) @(negedge clk);
    latchPulse = 1'b1;
    @(negedge clk);
    latchPulse = 1'b0;
    repeat (6) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ### dv/ldl_latch_bank_checker.sv
// port checks for the latch bank
`timescale 1ns/1ps
`default_nettype none
module ldl_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        clkIn,
  input wire logic        latchPulse,
  input wire logic        clkOut,
  input wire logic        datOut,
  input wire logic [20:0] currentCorrection,
  input wire logic [2:0]  switchOnDutyCode,
  input wire logic [4:0]  anodeTargetCode,
  input wire logic [1:0]  linkTimingMode,
  input wire logic [3:0]  latchDelayCode,
  input wire logic [6:0]  onDutyPercent,
  input wire logic [15:0] anodeTargetMv,
  input wire logic        nvProgramReq
);
  localparam logic [6:0] PCT [8] = '{7'h12, 7'h1e, 7'h2a, 7'h37, 7'h43, 7'h50, 7'h56, 7'h56};
  logic [3:0] quiet;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // cycles since the link clock moved
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quiet <= 4'hf;
    end else if ($changed(clkIn)) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hf) begin
      quiet <= quiet + 4'h1;
    end
  end
  AST_CLK_FWD: assert property ((linkTimingMode == 2'h0 && $stable(clkIn)) [*6] |-> clkOut == clkIn)
    else $error("forwarded clock wrong");
  AST_DAT_FWD: assert property ($changed(datOut) |-> quiet < 4'ha)
    else $error("data out moved without link edge");
  AST_PARAM_HOLD: assert property ($changed({switchOnDutyCode, anodeTargetCode, linkTimingMode,
    latchDelayCode}) |-> $past(latchPulse) || $past(latchPulse, 2))
    else $error("parameter changed without strobe");
  AST_CORR_HOLD: assert property ($changed(currentCorrection) && !$past(rst, 2) && !$past(rst, 3)
    |-> $past(latchPulse) || $past(latchPulse, 2))
    else $error("correction changed without strobe");
  AST_DUTY_DEC: assert property ($stable(switchOnDutyCode) [*2] |-> onDutyPercent == PCT[switchOnDutyCode])
    else $error("duty percent decode wrong");
  AST_MV_LOW: assert property (anodeTargetCode == 5'h00 && $past(anodeTargetCode) == 5'h00 |-> anodeTargetMv == 16'h1b58)
    else $error("target mv wrong at code 0");
  AST_MV_HIGH: assert property (anodeTargetCode == 5'h1f && $past(anodeTargetCode) == 5'h1f |-> anodeTargetMv == 16'h4268)
    else $error("target mv wrong at top code");
  AST_NV_ONE: assert property (nvProgramReq |=> !nvProgramReq)
    else $error("program request longer than one cycle");
  AST_NV_CAUSE: assert property ($rose(nvProgramReq) |-> $past(latchPulse) || $past(latchPulse, 2))
    else $error("program request without strobe");
endmodule
bind ldl_latch_bank ldl_checker chk_u (.clk(clk), .rst(rst), .clkIn(clkIn), .latchPulse(latchPulse),
  .clkOut(clkOut), .datOut(datOut), .currentCorrection(currentCorrection),
  .switchOnDutyCode(switchOnDutyCode), .anodeTargetCode(anodeTargetCode),
  .linkTimingMode(linkTimingMode), .latchDelayCode(latchDelayCode),
  .onDutyPercent(onDutyPercent), .anodeTargetMv(anodeTargetMv), .nvProgramReq(nvProgramReq));
`default_nettype wire

// ### dv/tb_top.sv
// self-checking bench for the latch bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [20:0] NV_DC = 21'h15a5c3;
  localparam logic [6:0]  PCT [8] = '{7'h12, 7'h1e, 7'h2a, 7'h37, 7'h43, 7'h50, 7'h56, 7'h56};
  logic        clk, rst, clkIn, datIn, latchPulse, intTick, clkOut, datOut, nvReq;
  logic [2:0]  leds, duty, seen;
  logic [6:0]  bright, pct, bexp;
  logic [20:0] corr;
  logic [4:0]  tgt;
  logic [1:0]  mode;
  logic [3:0]  dly;
  logic [15:0] mv, seed;
  logic [35:0] r;
  int          fail_count, comparisons;
  int          nvPulses;
  ldl_latch_bank #(.NV_CORR_DEFAULT(NV_DC)) dut_u (.clk(clk), .rst(rst), .clkIn(clkIn),
    .datIn(datIn), .latchPulse(latchPulse), .intTick(intTick), .clkOut(clkOut), .datOut(datOut),
    .ledSinkOutput(leds), .globalBrightness(bright), .currentCorrection(corr),
    .switchOnDutyCode(duty), .anodeTargetCode(tgt), .linkTimingMode(mode),
    .latchDelayCode(dly), .onDutyPercent(pct), .anodeTargetMv(mv), .nvProgramReq(nvReq));
  ldl_host host_u (.clk(clk), .clkIn(clkIn), .datIn(datIn), .latchPulse(latchPulse));
  // pseudo random source
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // expected target in millivolts: 7 V plus 10n/31 V
  function automatic logic [20:0] exp_mv(input logic [4:0] n);
    logic [31:0] w;
    w = 32'h1b58 + (32'(n) * 32'h2710) / 32'h1f;
    return w[20:0];
  endfunction
  // count one-cycle program requests
  always @(negedge clk) begin
    if (nvReq === 1'b1) begin
      nvPulses++;
    end
  end
  task automatic roll();
    seed = lfsr(seed);
    r = {seed[11:0], seed ^ 16'h5a3c, ~seed[7:0]};
  endtask
  task automatic chk(input string nm, input logic [20:0] exp, input logic [20:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // random pwm ticks while collecting lit outputs
  task automatic run(input int n);
    seen = 3'h0;
    repeat (n) begin
      @(negedge clk);
      seed = lfsr(seed);
      intTick = seed[0];
      seen = seen | leds;
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // watchdog
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
  // main sequence
  initial begin
    fail_count = 0;
    comparisons = 0;
    nvPulses = 0;
    seed = 16'h004c;
    rst = 1'b1;
    intTick = 1'b0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk("bright", 21'h7f, bright);
    chk("delay", 21'hf, dly);
    chk("pct", 21'h12, pct);
    chk("mv", 21'h1b58, mv);
    chk("corr", NV_DC, corr);
    host_u.send({4'he, 36'h0}, 0);
    chk("corr locked", NV_DC, corr);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      roll();
      r[35:28] = 8'ha5;
      r[2:0] = i[2:0];
      r[9:8] = ~i[1:0];
      r[7:3] = (i == 7) ? 5'h1f : (i == 0) ? 5'h00 : r[7:3];
      host_u.send({4'hc, r}, (i == 3) ? 3 : 0);
      chk("duty", r[2:0], duty);
      chk("target", r[7:3], tgt);
      chk("mode", r[9:8], mode);
      chk("delay", r[13:10], dly);
      chk("pct", PCT[i], pct);
      chk("mv", exp_mv(r[7:3]), mv);
      chk("dat out", 21'h1, datOut);
      chk("clk out", 21'h0, clkOut);
    end
    chk("mv top", 21'h4268, mv);
    chk("nv pulses", 21'h8, nvPulses[20:0]);
    $display("parameter test done");
    roll();
    r[11:7] = 5'h12;
    host_u.send({4'hf, r}, 0);
    chk("bright", r[6:0], bright);
    bexp = r[6:0];
    roll();
    host_u.send({4'he, r}, 0);
    chk("corr", r[20:0], corr);
    host_u.send({4'h3, ~r}, 0);
    chk("corr kept", r[20:0], corr);
    $display("control test done");
    for (int c = 0; c < 3; c++) begin
      host_u.send({4'h0, 36'hfff << (12 * c)}, 0);
      run(300);
      chk("lit", 21'h1 << c, seen);
    end
    roll();
    r[11:7] = 5'h1d; // refresh, link clock, timing reset, correction writes
    host_u.send({4'hf, r}, 1);
    chk("bright held", bexp, bright);
    host_u.send({4'h0, 36'hfff}, 0);
    chk("bright copy", r[6:0], bright);
    run(50);
    chk("reset lit", 21'h1, seen);
    host_u.send({4'h0, 36'h0}, 0);
    run(100);
    chk("dark", 21'h0, seen);
    $display("pwm test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
